// ==== rtl/pga_port.sv ====
// Top of the eight-pin general purpose port A with its register file.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
module pga_port (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // Peripheral side
    output logic pwm_fault_input,
    output logic [7:0] analog_sel
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] direction_port_a_r;
    logic [7:0] output_latch_port_a_r;
    logic [7:0] analog_sel_r;
    logic [7:0] periph_en_r;
    logic [2:0] config_r;
    logic [7:0] rdata_r;
    logic [7:0] dig_in;
    logic [7:0] osc_mask;
    logic [7:0] vref_mask;
    logic [7:0] rd_val;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    assign osc_mask = config_r[pga_pkg::PGA_CFG_OSC_BIT] ? pga_pkg::PGA_OSC_PINS : 8'h00;
    assign vref_mask = config_r[pga_pkg::PGA_CFG_VREF_BIT] ?
        (8'h01 << pga_pkg::PGA_PIN_VREF) : 8'h00;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            direction_port_a_r <= pga_pkg::PGA_DIR_RESET;
        end else if (reg_wr && hit(reg_addr, pga_pkg::PGA_OFF_DIRECTION)) begin
            direction_port_a_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_latch_port_a_r <= pga_pkg::PGA_LAT_RESET;
        end else if (reg_wr && (hit(reg_addr, pga_pkg::PGA_OFF_LATCH) ||
                                hit(reg_addr, pga_pkg::PGA_OFF_PIN_LEVEL))) begin
            output_latch_port_a_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            analog_sel_r <= pga_pkg::PGA_ANALOG_RESET;
        end else if (reg_wr && hit(reg_addr, pga_pkg::PGA_OFF_ANALOG_SEL)) begin
            analog_sel_r <= reg_wdata & pga_pkg::PGA_ANALOG_CAPABLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            periph_en_r <= pga_pkg::PGA_PERIPH_RESET;
        end else if (reg_wr && hit(reg_addr, pga_pkg::PGA_OFF_PERIPH_EN)) begin
            periph_en_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            config_r <= pga_pkg::PGA_CFG_RESET;
        end else if (reg_wr && hit(reg_addr, pga_pkg::PGA_OFF_CONFIG)) begin
            config_r <= reg_wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Pin cells
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < pga_pkg::PGA_WIDTH; gi++) begin : g_pin
            pga_pin_cell u_cell (
                .dir_in(direction_port_a_r[gi]),
                .latch_val(output_latch_port_a_r[gi]),
                .analog_on(analog_sel_r[gi]),
                .periph_on(periph_en_r[gi]),
                .kill_all(vref_mask[gi]),
                .not_gpio(osc_mask[gi]),
                .pad_in(pin_in[gi]),
                .pad_out(pin_out[gi]),
                .pad_oe(pin_oe[gi]),
                .dig_in(dig_in[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Fault input routing
    // ------------------------------------------------------------
    // The fault path bypasses the analog gate; it is a digital peripheral input.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_fault_input <= 1'b0;
        end else if (config_r[pga_pkg::PGA_CFG_FAULT_BIT]) begin
            pwm_fault_input <= pin_in[pga_pkg::PGA_PIN_FAULT_HI];
        end else begin
            pwm_fault_input <= pin_in[pga_pkg::PGA_PIN_FAULT_LO];
        end
    end

    assign analog_sel = analog_sel_r;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            pga_pkg::PGA_OFF_PIN_LEVEL: rd_val = dig_in;
            pga_pkg::PGA_OFF_DIRECTION: rd_val = direction_port_a_r & ~osc_mask;
            pga_pkg::PGA_OFF_LATCH: rd_val = output_latch_port_a_r & ~osc_mask;
            pga_pkg::PGA_OFF_ANALOG_SEL: rd_val = analog_sel_r;
            pga_pkg::PGA_OFF_PERIPH_EN: rd_val = periph_en_r;
            pga_pkg::PGA_OFF_CONFIG: rd_val = {5'h00, config_r};
            default: rd_val = 8'h00;
        endcase
    end

    // Read data is held only in the cycle after the strobe.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_val;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;
endmodule

// ==== rtl/pga_pkg.sv ====
// Package of register offsets, reset values and pin positions for the port A block.
package pga_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] PGA_OFF_PIN_LEVEL = 4'h0;
    localparam logic [3:0] PGA_OFF_DIRECTION = 4'h1;
    localparam logic [3:0] PGA_OFF_LATCH = 4'h2;
    localparam logic [3:0] PGA_OFF_ANALOG_SEL = 4'h3;
    localparam logic [3:0] PGA_OFF_PERIPH_EN = 4'h4;
    localparam logic [3:0] PGA_OFF_CONFIG = 4'h5;
    // ------------------------------------------------------------
    // Widths, reset values and field positions
    // ------------------------------------------------------------
    localparam int PGA_WIDTH = 8;
    localparam logic [7:0] PGA_DIR_RESET = 8'hff;
    localparam logic [7:0] PGA_LAT_RESET = 8'h00;
    localparam logic [7:0] PGA_ANALOG_RESET = 8'h33;
    localparam logic [7:0] PGA_PERIPH_RESET = 8'h00;
    localparam logic [7:0] PGA_OSC_PINS = 8'hc0;
    localparam logic [7:0] PGA_ANALOG_CAPABLE = 8'h37;
    localparam int PGA_CFG_OSC_BIT = 0;
    localparam int PGA_CFG_FAULT_BIT = 1;
    localparam int PGA_CFG_VREF_BIT = 2;
    localparam logic [2:0] PGA_CFG_RESET = 3'h0;
    localparam int PGA_PIN_VREF = 2;
    localparam int PGA_PIN_FAULT_LO = 5;
    localparam int PGA_PIN_FAULT_HI = 7;
endpackage

// ==== rtl/pga_pin_cell.sv ====
// One port pin: driver enable, output value and gated digital input.
`timescale 1ns/10ps
module pga_pin_cell (
    // Control
    input wire logic dir_in,
    input wire logic latch_val,
    input wire logic analog_on,
    input wire logic periph_on,
    input wire logic kill_all,
    input wire logic not_gpio,
    // Pad
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    // Result
    output logic dig_in
);
    // ------------------------------------------------------------
    // Driver and input gating
    // ------------------------------------------------------------
    // The analog selection is left out of the driver enable on purpose.
    assign pad_oe = ~dir_in & ~periph_on & ~kill_all & ~not_gpio;
    assign pad_out = latch_val;
    assign dig_in = pad_in & ~analog_on & ~kill_all & ~not_gpio;
endmodule

// ==== sim/pga_port_properties.sv ====
// Checker of register and pin relations of the port A block.
`timescale 1ns/10ps
module pga_port_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and peripheral side
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic pwm_fault_input,
    input wire logic [7:0] analog_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_LAT_WR: assert property
        (reg_wr && reg_addr == 4'h2 |=> pin_out == $past(reg_wdata)) else $error("latch write lost");
    AST_LVL_WR: assert property
        (reg_wr && reg_addr == 4'h0 |=> pin_out == $past(reg_wdata)) else $error("level write lost");
    AST_DIR_WR: assert property
        (reg_wr && reg_addr == 4'h1 |=> (pin_oe & $past(reg_wdata)) == 8'h00) else $error("input driven");
    AST_RD_IDLE: assert property
        (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read slot");
    AST_UNMAPPED: assert property
        (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_LAT_RD: assert property
        (reg_rd && reg_addr == 4'h2 |=> (reg_rdata & 8'h3f) == (pin_out & 8'h3f)) else $error("latch read");
    AST_LVL_ANA: assert property
        (reg_rd && reg_addr == 4'h0 |=> (reg_rdata & $past(analog_sel)) == 8'h00) else $error("analog read");
    AST_FAULT: assert property
        (pin_in[5] == pin_in[7] |=> pwm_fault_input == $past(pin_in[5])) else $error("fault input");
    cover property (reg_rd && reg_addr == 4'h0);
    cover property (reg_wr && reg_addr == 4'h5);
    cover property ($rose(pwm_fault_input));
endmodule
bind pga_port pga_port_properties pga_port_properties_i (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pwm_fault_input(pwm_fault_input), .analog_sel(analog_sel));

// ==== sim/pga_pins_model.sv ====
// Model of the board side of the port A pins.
`timescale 1ns/10ps
module pga_pins_model (
    // From the port
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // Board level on floating pins
    input wire logic [7:0] ext_lvl,
    // Level seen at the pins
    output logic [7:0] pin_in
);
    // A driven pin shows the port's value; the board only wins where the port floats.
    assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

// ==== sim/pga_port_tb.sv ====
// Self-checking bench of the port A block.
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module pga_port_tb;
    logic clk, reset_n, reg_wr, reg_rd, fault;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, ext_lvl, analog_sel;
    int mismatches = 0;
    int tests_run = 0;
    pga_port pga_port_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pwm_fault_input(fault),
        .analog_sel(analog_sel));
    pga_pins_model pga_pins_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
        .pin_in(pin_in));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("rdata", e, reg_rdata)
    endtask
    task automatic end_sim();
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #20000;
        mismatches++;
        end_sim();
    end
    initial begin
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        ext_lvl = 8'hff;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(4'h1, 8'hff);
        rd(4'h2, 8'h00);
        rd(4'h0, 8'hcc);
        `CHK("analog", 8'h33, analog_sel)
        `CHK("oe", 8'h00, pin_oe)
        wr(4'h1, 8'h00);
        wr(4'h0, 8'ha5);
        `CHK("oe", 8'hff, pin_oe)
        `CHK("out", 8'ha5, pin_out)
        rd(4'h2, 8'ha5);
        rd(4'h0, 8'h84);
        wr(4'h5, 8'h01);
        `CHK("oe", 8'h3f, pin_oe)
        rd(4'h2, 8'h25);
        rd(4'h0, 8'h04);
        wr(4'h5, 8'h04);
        `CHK("oe", 8'hfb, pin_oe)
        rd(4'h0, 8'h80);
        wr(4'h4, 8'h08);
        `CHK("oe", 8'hf3, pin_oe)
        wr(4'h5, 8'h00);
        wr(4'h2, 8'h20);
        repeat (2) @(posedge clk);
        #1;
        `CHK("fault", 1'b1, fault)
        wr(4'h5, 8'h02);
        repeat (2) @(posedge clk);
        #1;
        `CHK("fault", 1'b0, fault)
        wr(4'h1, 8'hff);
        wr(4'h3, 8'hff);
        rd(4'h3, 8'h37);
        `CHK("oe", 8'h00, pin_oe)
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        end_sim();
    end
endmodule
